// ==== design/afpp_addon.sv ====
// afpp_addon.sv: add-on end driving fifo strobes and finishing pass-thru cycles
`timescale 1ns/1ps
`default_nettype none
`include "afpp_defs.svh"
module afpp_addon import afpp_pkg::*; #(
    parameter int DATA_W = `AFPP_DATA_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    afpp_if.addon port,
    input wire logic i_mode16,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_rd_req,
    output logic o_rd_valid,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_pt_valid,
    output logic o_pt_write,
    output logic [`AFPP_REGION_W-1:0] o_pt_region,
    output logic [DATA_W-1:0] o_pt_addr,
    input wire logic i_pt_done,
    input wire logic [DATA_W-1:0] i_pt_rdata
);
    typedef enum logic [1:0] {
        AFPP_AO_IDLE = 2'b00,
        AFPP_AO_ADDR = 2'b01,
        AFPP_AO_WAIT = 2'b10,
        AFPP_AO_DONE = 2'b11
    } afpp_ao_state_t;
    typedef struct packed {
        afpp_ao_state_t st;
        logic wr_n;
        logic rd_n;
        logic rd_pend;
        logic rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic [DATA_W-1:0] pt_addr;
        logic [DATA_W-1:0] drive;
        logic drive_oe;
        logic addr_cap;
    } afpp_ao_st_t;
    afpp_ao_st_t s_q, s_d;

    assign o_wr_ready = s_q.wr_n && port.outbound_fifo_full == 1'b0 && s_q.st == AFPP_AO_IDLE;

    always_comb begin
        s_d = s_q;
        s_d.wr_n = 1'b1;
        s_d.rd_n = 1'b1;
        s_d.rd_valid = 1'b0;
        s_d.drive_oe = 1'b0;
        // the fifo word stands on the bus only in the cycle after the strobe
        if (s_q.rd_pend && s_q.rd_n) begin
            s_d.rd_pend = 1'b0;
            s_d.rd_valid = 1'b1;
            s_d.rd_data = port.dq;
        end
        // likewise the address follows its request by one cycle
        if (s_q.addr_cap) begin
            s_d.addr_cap = 1'b0;
            s_d.pt_addr = port.dq;
        end
        unique case (s_q.st)
            AFPP_AO_IDLE: begin
                // strobes only when the status allows, never beside an address phase
                if (!port.passthru_attention_n) begin
                    s_d.st = AFPP_AO_ADDR;
                end else if (i_wr_valid && o_wr_ready) begin
                    s_d.wr_n = 1'b0;
                    s_d.drive = i_wr_data;
                    s_d.drive_oe = 1'b1;
                end else if (i_rd_req && !port.inbound_fifo_empty && s_q.rd_n && !s_q.rd_pend) begin
                    s_d.rd_n = 1'b0;
                    s_d.rd_pend = 1'b1;
                end
            end
            AFPP_AO_ADDR: begin
                s_d.addr_cap = 1'b1;
                s_d.st = AFPP_AO_WAIT;
            end
            AFPP_AO_WAIT: begin
                if (i_pt_done && !s_q.addr_cap) begin
                    s_d.drive = i_pt_rdata;
                    s_d.drive_oe = !port.passthru_direction;
                    s_d.st = AFPP_AO_DONE;
                end
            end
            AFPP_AO_DONE: begin
                s_d.st = AFPP_AO_IDLE;
            end
            default: s_d.st = AFPP_AO_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{st: AFPP_AO_IDLE, wr_n: 1'b1, rd_n: 1'b1, rd_pend: 1'b0,
                     rd_valid: 1'b0, rd_data: '0, pt_addr: '0, drive: '0, drive_oe: 1'b0,
                     addr_cap: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign port.fifo_direct_write_n = s_q.wr_n;
    assign port.fifo_direct_read_n = s_q.rd_n;
    assign port.passthru_addr_request_n = !(s_q.st == AFPP_AO_ADDR);
    assign port.passthru_done_n = !(s_q.st == AFPP_AO_DONE);
    assign port.bus_width_n16 = i_mode16 ? `AFPP_MODE_16 : `AFPP_MODE_32;
    assign port.dq_addon_out = s_q.drive;
    assign port.dq_addon_oe = s_q.drive_oe;
    assign o_rd_valid = s_q.rd_valid;
    assign o_rd_data = s_q.rd_data;
    assign o_pt_valid = (s_q.st == AFPP_AO_WAIT) && !s_q.addr_cap;
    assign o_pt_write = port.passthru_direction;
    assign o_pt_region = port.passthru_region;
    assign o_pt_addr = s_q.pt_addr;
endmodule : afpp_addon
`default_nettype wire

// ==== design/afpp_defs.svh ====
// afpp_defs.svh: constants for the add-on fifo and pass-thru port
`ifndef AFPP_DEFS_SVH
`define AFPP_DEFS_SVH
`define AFPP_DATA_W 32
`define AFPP_HALF_W 16
`define AFPP_FIFO_DEPTH 32
`define AFPP_BE_W 4
`define AFPP_REGION_W 2
`define AFPP_REGION_FIRST 2'h0
`define AFPP_REGION_SECOND 2'h1
`define AFPP_BE_NONE 4'hf
`define AFPP_MODE_32 1'b0
`define AFPP_MODE_16 1'b1
`endif

// ==== design/afpp_device.sv ====
// afpp_device.sv: bridge end of the add-on fifo and pass-thru port
// Functional notes
// - direct write strobe pushes outbound fifo
// - direct read strobe presents next inbound word
// - fifo access width follows strap
// - full output low requests dma write
// - empty output low requests dma read
// - attention low while decoded cycle pending
// - burst low when cycle requests burst
// - add-on pulls done low when finished
// - region code names decoding base register
// - byte enables held valid during attention
// - address request drives address onto bus
// - add-on idles other controls during address
// - direction output valid during attention
// - add-on reset follows pci reset, software
// - buffered pci clock forwarded to add-on
// - interrupt low on significant internal event
// - strap low is 32-bit, high 16-bit
`timescale 1ns/1ps
`default_nettype none
`include "afpp_defs.svh"
module afpp_device import afpp_pkg::*; #(
    parameter int DATA_W = `AFPP_DATA_W,
    parameter int FIFO_DEPTH = `AFPP_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    afpp_if.device port,
    // pci core side: decoded pass-thru cycles
    input wire logic i_cycle_valid,
    output logic o_cycle_ready,
    input wire afpp_cycle_t i_cycle,
    output logic o_cycle_done,
    output logic [DATA_W-1:0] o_cycle_rdata,
    input wire logic [DATA_W-1:0] i_cycle_wdata,
    // pci core side: fifo streams
    output logic o_ob_valid,
    input wire logic i_ob_ready,
    output logic [DATA_W-1:0] o_ob_data,
    input wire logic i_ib_valid,
    output logic o_ib_ready,
    input wire logic [DATA_W-1:0] i_ib_data,
    // system controls
    input wire logic i_sw_reset,
    input wire logic i_event
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        afpp_pt_state_t pt_state;
        afpp_cycle_t cur;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
        logic irq_n;
        logic wr_n_prev;
        logic rd_n_prev;
    } afpp_dev_st_t;
    afpp_dev_st_t s_q, s_d;

    logic mode16;
    logic ob_in_ready, ib_out_valid;
    logic wr_fire, rd_fire, done_fire;
    logic [DATA_W-1:0] ib_out_data, wr_word;

    // narrow mode keeps the upper half zero so the pci side sees a clean word
    function automatic logic [DATA_W-1:0] afpp_width(input logic [DATA_W-1:0] v,
                                                     input logic narrow);
        afpp_width = narrow ? {{(DATA_W-`AFPP_HALF_W){1'b0}}, v[`AFPP_HALF_W-1:0]} : v;
    endfunction : afpp_width

    assign mode16 = (port.bus_width_n16 == `AFPP_MODE_16);
    // strobes act once per low level entry, so a held strobe moves one word
    assign wr_fire = !port.fifo_direct_write_n && s_q.wr_n_prev && ob_in_ready;
    assign rd_fire = !port.fifo_direct_read_n && s_q.rd_n_prev && ib_out_valid;
    assign done_fire = (s_q.pt_state == AFPP_PT_ATTN) && !port.passthru_done_n;
    assign wr_word = afpp_width(port.dq, mode16);

    // ************************************************************
    // fifos
    // ************************************************************
    afpp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_outbound (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(wr_fire),
        .o_in_ready(ob_in_ready),
        .i_in_data(wr_word),
        .o_out_valid(o_ob_valid),
        .i_out_ready(i_ob_ready),
        .o_out_data(o_ob_data)
    );
    afpp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_inbound (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(i_ib_valid),
        .o_in_ready(o_ib_ready),
        .i_in_data(i_ib_data),
        .o_out_valid(ib_out_valid),
        .i_out_ready(rd_fire),
        .o_out_data(ib_out_data)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.wr_n_prev = port.fifo_direct_write_n;
        s_d.rd_n_prev = port.fifo_direct_read_n;
        s_d.irq_n = !i_event;
        s_d.dq_oe = 1'b0;
        if (rd_fire) begin
            s_d.dq_out = afpp_width(ib_out_data, mode16);
            s_d.dq_oe = 1'b1;
        end else if (!port.passthru_addr_request_n && s_q.pt_state == AFPP_PT_ATTN) begin
            s_d.dq_out = afpp_width(s_q.cur.addr, mode16);
            s_d.dq_oe = 1'b1;
        end
        unique case (s_q.pt_state)
            AFPP_PT_IDLE: begin
                if (i_cycle_valid) begin
                    s_d.cur = i_cycle;
                    s_d.wdata = i_cycle_wdata;
                    s_d.pt_state = AFPP_PT_ATTN;
                end
            end
            AFPP_PT_ATTN: begin
                if (done_fire) begin
                    // a pending cycle follows back to back without dropping attention
                    if (i_cycle_valid) begin
                        s_d.cur = i_cycle;
                        s_d.wdata = i_cycle_wdata;
                    end else begin
                        s_d.pt_state = AFPP_PT_IDLE;
                    end
                end
            end
            default: s_d.pt_state = AFPP_PT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{pt_state: AFPP_PT_IDLE, cur: '0, wdata: '0, dq_out: '0,
                     dq_oe: 1'b0, irq_n: 1'b1, wr_n_prev: 1'b1, rd_n_prev: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_cycle_ready = (s_q.pt_state == AFPP_PT_IDLE) || done_fire;
    assign o_cycle_done = done_fire;
    // on a read cycle the add-on places its answer on the bus with done
    assign o_cycle_rdata = afpp_width(port.dq, mode16);

    assign port.outbound_fifo_full = !ob_in_ready;
    assign port.inbound_fifo_empty = !ib_out_valid;
    assign port.passthru_attention_n = (s_q.pt_state != AFPP_PT_ATTN);
    assign port.passthru_burst_n = !(s_q.cur.burst && s_q.pt_state == AFPP_PT_ATTN);
    assign port.passthru_region = s_q.cur.region;
    assign port.passthru_byte_en_n = (s_q.pt_state == AFPP_PT_ATTN) ?
                                     s_q.cur.byte_en_n : `AFPP_BE_NONE;
    assign port.passthru_direction = s_q.cur.write;
    // unsynchronised on purpose: reset must reach the add-on even without a clock
    assign port.addon_reset_n = !(i_rst || i_sw_reset);
    assign port.addon_clock_out = i_clk;
    assign port.addon_irq_n = s_q.irq_n;
    // write cycles put the pass-thru data on dq_dev_out while attention waits for done, with dq_dev_oe left low
    assign port.dq_dev_out = (s_q.pt_state == AFPP_PT_ATTN && s_q.cur.write &&
                              !s_q.dq_oe) ? afpp_width(s_q.wdata, mode16) : s_q.dq_out;
    assign port.dq_dev_oe = s_q.dq_oe;
endmodule : afpp_device
`default_nettype wire

// ==== design/afpp_fifo.sv ====
// afpp_fifo.sv: synchronous flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module afpp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } afpp_fifo_st_t;
    afpp_fifo_st_t s_q, s_d;
    logic push, pop;

    function automatic logic [AW-1:0] afpp_inc(input logic [AW-1:0] p);
        afpp_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : afpp_inc

    assign o_in_ready = (s_q.count != (AW+1)'(DEPTH));
    assign o_out_valid = (s_q.count != '0);
    assign o_out_data = s_q.mem[s_q.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr_ptr] = i_in_data;
            s_d.wr_ptr = afpp_inc(s_q.wr_ptr);
        end
        if (pop) begin
            s_d.rd_ptr = afpp_inc(s_q.rd_ptr);
        end
        if (push && !pop) begin
            s_d.count = s_q.count + (AW+1)'(1);
        end else if (pop && !push) begin
            s_d.count = s_q.count - (AW+1)'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : afpp_fifo
`default_nettype wire

// ==== design/afpp_if.sv ====
// afpp_if.sv: add-on side pins between the bridge and add-on logic
`timescale 1ns/1ps
`default_nettype none
interface afpp_if;
    logic fifo_direct_write_n;
    logic fifo_direct_read_n;
    logic outbound_fifo_full;
    logic inbound_fifo_empty;
    logic passthru_attention_n;
    logic passthru_burst_n;
    logic passthru_done_n;
    logic [1:0] passthru_region;
    logic [3:0] passthru_byte_en_n;
    logic passthru_addr_request_n;
    logic passthru_direction;
    logic addon_reset_n;
    logic addon_clock_out;
    logic addon_irq_n;
    logic bus_width_n16;
    logic [31:0] dq_dev_out;
    logic dq_dev_oe;
    logic [31:0] dq_addon_out;
    logic dq_addon_oe;
    // resolved data bus; contention reads as the device value
    logic [31:0] dq;
    assign dq = dq_dev_oe ? dq_dev_out : (dq_addon_oe ? dq_addon_out : 32'h0000_0000);

    modport device (
        input fifo_direct_write_n, fifo_direct_read_n, passthru_done_n,
        input passthru_addr_request_n, bus_width_n16, dq,
        output outbound_fifo_full, inbound_fifo_empty, passthru_attention_n,
        output passthru_burst_n, passthru_region, passthru_byte_en_n,
        output passthru_direction, addon_reset_n, addon_clock_out, addon_irq_n,
        output dq_dev_out, dq_dev_oe
    );
    modport addon (
        output fifo_direct_write_n, fifo_direct_read_n, passthru_done_n,
        output passthru_addr_request_n, bus_width_n16, dq_addon_out, dq_addon_oe,
        input outbound_fifo_full, inbound_fifo_empty, passthru_attention_n,
        input passthru_burst_n, passthru_region, passthru_byte_en_n,
        input passthru_direction, addon_reset_n, addon_clock_out, addon_irq_n, dq
    );
endinterface : afpp_if
`default_nettype wire

// ==== design/afpp_pkg.sv ====
// afpp_pkg.sv: types shared by both ends of the add-on port
`include "afpp_defs.svh"
package afpp_pkg;
    // one decoded pci cycle handed to the add-on side
    typedef struct packed {
        logic [`AFPP_DATA_W-1:0] addr;
        logic [`AFPP_REGION_W-1:0] region;
        logic [`AFPP_BE_W-1:0] byte_en_n;
        logic write;
        logic burst;
    } afpp_cycle_t;

    typedef enum logic [1:0] {
        AFPP_PT_IDLE = 2'b00,
        AFPP_PT_ATTN = 2'b01
    } afpp_pt_state_t;
endpackage : afpp_pkg

// ==== sim/afpp_checker.sv ====
// afpp_checker.sv: concurrent checks on the pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module afpp_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic fifo_direct_write_n,
    input wire logic fifo_direct_read_n,
    input wire logic outbound_fifo_full,
    input wire logic inbound_fifo_empty,
    input wire logic passthru_attention_n,
    input wire logic passthru_burst_n,
    input wire logic passthru_done_n,
    input wire logic [1:0] passthru_region,
    input wire logic [3:0] passthru_byte_en_n,
    input wire logic passthru_addr_request_n,
    input wire logic passthru_direction,
    input wire logic addon_reset_n,
    input wire logic dq_dev_oe
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_idle_quals;
        passthru_attention_n |-> passthru_byte_en_n == 4'hf && passthru_burst_n;
    endproperty
    a_idle_quals: assert property (p_idle_quals)
        else $error("qualifiers active while idle");
    property p_fields_hold;
        !passthru_attention_n && passthru_done_n |=> $stable(passthru_region)
            && $stable(passthru_byte_en_n) && $stable(passthru_direction)
            && $stable(passthru_burst_n);
    endproperty
    a_fields_hold: assert property (p_fields_hold)
        else $error("cycle fields moved during attention");
    property p_attn_holds;
        !passthru_attention_n && passthru_done_n |=> !passthru_attention_n;
    endproperty
    a_attn_holds: assert property (p_attn_holds)
        else $error("attention dropped without done");
    property p_addr_drive;
        $fell(passthru_addr_request_n) && !passthru_attention_n |=> dq_dev_oe;
    endproperty
    a_addr_drive: assert property (p_addr_drive)
        else $error("address not driven after request");
    property p_read_drive;
        $fell(fifo_direct_read_n) && !inbound_fifo_empty |=> dq_dev_oe;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("fifo word not driven after read strobe");
    property p_oe_cause;
        dq_dev_oe |-> !$past(fifo_direct_read_n) || !$past(passthru_addr_request_n);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("device drove bus without a request");
    property p_full_cause;
        $rose(outbound_fifo_full) |-> !$past(fifo_direct_write_n);
    endproperty
    a_full_cause: assert property (p_full_cause)
        else $error("full rose without a write strobe");
    property p_empty_cause;
        $rose(inbound_fifo_empty) |-> !$past(fifo_direct_read_n);
    endproperty
    a_empty_cause: assert property (p_empty_cause)
        else $error("empty rose without a read strobe");
    property p_addr_quiet;
        !passthru_addr_request_n |-> fifo_direct_write_n && fifo_direct_read_n
            && passthru_done_n;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("other control active during address request");
    // the add-on reset is asynchronous, so it is checked even inside reset
    property p_reset_out;
        disable iff (1'b0) i_rst |-> !addon_reset_n;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("add-on reset high during reset");
    c_read: cover property ($fell(fifo_direct_read_n) && !inbound_fifo_empty);
    c_addr: cover property ($fell(passthru_addr_request_n));
    c_full: cover property ($rose(outbound_fifo_full));
    c_done: cover property (!passthru_attention_n && !passthru_done_n);
endmodule : afpp_checker
`default_nettype wire

// ==== sim/tb_addon_fifo_passthru_port.sv ====
// tb_addon_fifo_passthru_port.sv: bench joining the bridge end and the add-on end
`timescale 1ns/1ps
`default_nettype none
`include "afpp_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
$display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_addon_fifo_passthru_port import afpp_pkg::*; ();
    logic i_clk, i_rst, cyc_valid, cyc_ready, cyc_done, ob_valid, ob_ready, ib_valid, ib_ready;
    logic sw_rst, ev, mode16, wr_valid, wr_ready, rd_req, rd_valid, pt_valid, pt_write, pt_done;
    logic [31:0] cyc_rdata, ob_data, ib_data, wr_data, rd_data, pt_addr, pt_rdata, d;
    logic [1:0] pt_region;
    afpp_cycle_t cyc;
    afpp_cycle_t rows [4];
    logic [31:0] row_rd [4];
    logic row_m16 [4];
    int err_total, n_compared;

    afpp_if i_afpp_if ();
    afpp_device i_afpp_device (.i_clk(i_clk), .i_rst(i_rst), .port(i_afpp_if.device),
        .i_cycle_valid(cyc_valid), .o_cycle_ready(cyc_ready), .i_cycle(cyc),
        .o_cycle_done(cyc_done), .o_cycle_rdata(cyc_rdata), .i_cycle_wdata(32'h0f0f_1e1e),
        .o_ob_valid(ob_valid), .i_ob_ready(ob_ready), .o_ob_data(ob_data),
        .i_ib_valid(ib_valid), .o_ib_ready(ib_ready), .i_ib_data(ib_data),
        .i_sw_reset(sw_rst), .i_event(ev));
    afpp_addon i_afpp_addon (.i_clk(i_clk), .i_rst(i_rst), .port(i_afpp_if.addon),
        .i_mode16(mode16), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .i_wr_data(wr_data),
        .i_rd_req(rd_req), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_pt_valid(pt_valid),
        .o_pt_write(pt_write), .o_pt_region(pt_region), .o_pt_addr(pt_addr),
        .i_pt_done(pt_done), .i_pt_rdata(pt_rdata));
    afpp_checker i_afpp_checker (.i_clk(i_clk), .i_rst(i_rst),
        .fifo_direct_write_n(i_afpp_if.fifo_direct_write_n),
        .fifo_direct_read_n(i_afpp_if.fifo_direct_read_n),
        .outbound_fifo_full(i_afpp_if.outbound_fifo_full),
        .inbound_fifo_empty(i_afpp_if.inbound_fifo_empty),
        .passthru_attention_n(i_afpp_if.passthru_attention_n),
        .passthru_burst_n(i_afpp_if.passthru_burst_n),
        .passthru_done_n(i_afpp_if.passthru_done_n),
        .passthru_region(i_afpp_if.passthru_region),
        .passthru_byte_en_n(i_afpp_if.passthru_byte_en_n),
        .passthru_addr_request_n(i_afpp_if.passthru_addr_request_n),
        .passthru_direction(i_afpp_if.passthru_direction),
        .addon_reset_n(i_afpp_if.addon_reset_n), .dq_dev_oe(i_afpp_if.dq_dev_oe));

    // ********
    // helpers
    // ********
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    // bounded wait, so a dead handshake cannot hang the run
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        if (s !== 1'b1) begin
            err_total++;
            $display("ERROR %0t handshake timed out", $time);
        end
    endtask : wait_hi
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task automatic pt_row(input int r);
        cyc = rows[r];
        mode16 = row_m16[r];
        cyc_valid = 1'b1;
        wait_hi(cyc_ready);
        tick(1);
        cyc_valid = 1'b0;
        wait_hi(pt_valid);
        `CHK(i_afpp_if.passthru_attention_n, 1'b0)
        `CHK(i_afpp_if.passthru_region, cyc.region)
        `CHK(pt_region, cyc.region)
        `CHK(i_afpp_if.passthru_byte_en_n, cyc.byte_en_n)
        `CHK(i_afpp_if.passthru_direction, cyc.write)
        `CHK(pt_write, cyc.write)
        `CHK(i_afpp_if.passthru_burst_n, ~cyc.burst)
        `CHK(pt_addr[15:0], cyc.addr[15:0])
        if (!row_m16[r]) `CHK(pt_addr[31:16], cyc.addr[31:16])
        pt_rdata = row_rd[r];
        pt_done = 1'b1;
        tick(1);
        pt_done = 1'b0;
        wait_hi(cyc_done);
        if (!cyc.write) `CHK(cyc_rdata[15:0], row_rd[r][15:0])
        tick(1);
        `CHK(i_afpp_if.passthru_attention_n, 1'b1)
    endtask : pt_row

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #60000;
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        {i_rst, cyc_valid, ob_ready, ib_valid, sw_rst, ev, mode16} = 7'h40;
        {wr_valid, rd_req, pt_done, cyc, ib_data, wr_data, pt_rdata} = '0;
        err_total = 0;
        n_compared = 0;
        rows[0] = '{32'h1234_5678, `AFPP_REGION_FIRST, 4'h0, 1'b1, 1'b0};
        rows[1] = '{32'h89ab_cdef, `AFPP_REGION_SECOND, 4'ha, 1'b0, 1'b1};
        rows[2] = '{32'h5a5a_4321, `AFPP_REGION_FIRST, 4'hc, 1'b0, 1'b0};
        rows[3] = '{32'hfedc_0010, `AFPP_REGION_SECOND, 4'h3, 1'b1, 1'b1};
        row_rd = '{32'h0, 32'h3c3c_a5a5, 32'h0000_7e81, 32'h0};
        row_m16 = '{1'b0, 1'b0, 1'b1, 1'b1};
        tick(2);
        `CHK(i_afpp_if.passthru_attention_n, 1'b1)
        `CHK(i_afpp_if.passthru_byte_en_n, `AFPP_BE_NONE)
        `CHK({i_afpp_if.outbound_fifo_full, i_afpp_if.inbound_fifo_empty}, 2'h1)
        `CHK({i_afpp_if.addon_irq_n, i_afpp_if.addon_reset_n}, 2'h2)
        tick(14);
        i_rst = 1'b0;
        $display("test reset done");
        for (int r = 0; r < 4; r++) pt_row(r);
        $display("test passthru rows done");
        // outbound: fill while the pci side stalls, last word in 16-bit mode
        for (int i = 0; i < 32; i++) begin
            mode16 = (i == 31);
            wr_data = 32'h5a00_0000 + i * 32'h0001_0001;
            wr_valid = 1'b1;
            wait_hi(wr_ready);
            tick(1);
            wr_valid = 1'b0;
            tick(1);
        end
        tick(3);
        `CHK(i_afpp_if.outbound_fifo_full, 1'b1)
        ob_ready = 1'b1;
        for (int i = 0; i < 32; i++) begin
            d = 32'h5a00_0000 + i * 32'h0001_0001;
            wait_hi(ob_valid);
            `CHK(ob_data, (i == 31) ? {16'h0, d[15:0]} : d)
            tick(1);
        end
        tick(2);
        `CHK({i_afpp_if.outbound_fifo_full, ob_valid}, 2'h0)
        $display("test outbound done");
        mode16 = 1'b0;
        ib_valid = 1'b1;
        for (int i = 0; i < 32; i++) begin
            ib_data = 32'hc300_0000 + i * 32'h0003_0101;
            wait_hi(ib_ready);
            tick(1);
        end
        ib_valid = 1'b0;
        tick(3);
        `CHK({ib_ready, i_afpp_if.inbound_fifo_empty}, 2'h0)
        for (int i = 0; i < 32; i++) begin
            rd_req = 1'b1;
            tick(1);
            rd_req = 1'b0;
            wait_hi(rd_valid);
            `CHK(rd_data, 32'hc300_0000 + i * 32'h0003_0101)
            tick(1);
        end
        tick(3);
        `CHK(i_afpp_if.inbound_fifo_empty, 1'b1)
        $display("test inbound done");
        ev = 1'b1;
        tick(1);
        ev = 1'b0;
        `CHK(i_afpp_if.addon_irq_n, 1'b0)
        tick(1);
        `CHK(i_afpp_if.addon_irq_n, 1'b1)
        `CHK(i_afpp_if.addon_clock_out, 1'b1)
        #4;
        `CHK(i_afpp_if.addon_clock_out, 1'b0)
        sw_rst = 1'b1;
        #1;
        `CHK(i_afpp_if.addon_reset_n, 1'b0)
        sw_rst = 1'b0;
        tick(1);
        `CHK(i_afpp_if.addon_reset_n, 1'b1)
        $display("test system pins done");
        // reset in mid-cycle must drop attention at once
        cyc = rows[1];
        cyc_valid = 1'b1;
        wait_hi(pt_valid);
        cyc_valid = 1'b0;
        i_rst = 1'b1;
        #1;
        `CHK({i_afpp_if.passthru_attention_n, i_afpp_if.addon_reset_n}, 2'h2)
        tick(2);
        i_rst = 1'b0;
        tick(1);
        `CHK(i_afpp_if.passthru_attention_n, 1'b1)
        $display("test mid-run reset done");
        final_report();
    end
endmodule : tb_addon_fifo_passthru_port
`default_nettype wire
